// [hdl/sskdp_pkg.sv]
// constants and types for the soft starter kick, decel and protection block
package sskdp_pkg;
  // timing: every timer in the block counts 0.1 s ticks
  localparam int          CLK_PERIOD_NS   = 8;
  localparam longint      TICK_PERIOD_NS  = 100000000;
  localparam int          TICK_CYCLES     = int'(TICK_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [7:0]  KICK_MAX_TENTHS = 8'h14;
  localparam logic [3:0]  TENTHS_PER_SEC  = 4'hA;
  localparam logic [6:0]  PCT_SCALE       = 7'h64;
  // register word indices, byte address is four times the index
  localparam int          REG_COUNT       = 11;
  localparam logic [3:0]  IDX_CTRL        = 4'h0;
  localparam logic [3:0]  IDX_KICK        = 4'h1;
  localparam logic [3:0]  IDX_DECEL       = 4'h2;
  localparam logic [3:0]  IDX_RESTART     = 4'h3;
  localparam logic [3:0]  IDX_IMBAL       = 4'h4;
  localparam logic [3:0]  IDX_OVERCUR     = 4'h5;
  localparam logic [3:0]  IDX_UNDERCUR    = 4'h6;
  localparam logic [3:0]  IDX_GNDFAULT    = 4'h7;
  localparam logic [3:0]  IDX_MOTOR       = 4'h8;
  localparam logic [3:0]  IDX_RAMPINIT    = 4'h9;
  localparam logic [3:0]  IDX_STATUS      = 4'hA;
  // field positions
  localparam int          CTRL_RUN_BIT    = 0;
  localparam int          CTRL_CLEAR_BIT  = 1;
  localparam int          LVL_LSB         = 0;
  localparam int          DLY_LSB         = 16;
  localparam int          DEC_MODE_LSB    = 0;
  localparam int          DEC_BEGIN_LSB   = 8;
  localparam int          DEC_SHUT_LSB    = 16;
  localparam int          DEC_TIME_LSB    = 24;
  localparam int          KICK_DUR_LSB    = 8;
  localparam int          RAMP_VOLT_BIT   = 8;
  localparam int          CT_LSB          = 16;
  // reset values
  localparam logic [31:0] RST_CTRL        = 32'h0000_0000;
  localparam logic [31:0] RST_KICK        = 32'h0000_0800;
  localparam logic [31:0] RST_DECEL       = 32'h0A1E_3C00;
  localparam logic [31:0] RST_RESTART     = 32'h0000_0000;
  localparam logic [31:0] RST_IMBAL       = 32'h0002_0000;
  localparam logic [31:0] RST_OVERCUR     = 32'h0001_0000;
  localparam logic [31:0] RST_UNDERCUR    = 32'h0002_0000;
  localparam logic [31:0] RST_GNDFAULT    = 32'h0002_0000;
  localparam logic [31:0] RST_MOTOR       = 32'h0064_0064;
  localparam logic [31:0] RST_RAMPINIT    = 32'h0000_013C;
  // decel mode codes
  localparam logic [1:0]  DECEL_OFF       = 2'h0;
  localparam logic [1:0]  DECEL_OL_STOPS  = 2'h1;
  localparam logic [1:0]  DECEL_OL_RIDES  = 2'h2;
  // trip flag positions
  localparam int          TRIP_IMBAL      = 0;
  localparam int          TRIP_OVERCUR    = 1;
  localparam int          TRIP_UNDERCUR   = 2;
  localparam int          TRIP_GNDFAULT   = 3;
  localparam int          TRIP_OVERLOAD   = 4;
  localparam int          NUM_PROT        = 4;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_KICK,
    ST_ACCEL,
    ST_DECEL,
    ST_TRIP
  } sskdp_state_e;
endpackage

// [hdl/sskdp_soft_starter.sv]
// kick start, decel ramp, restart delay and current protection sequencer
// Notes on behaviour
// - a kick pulse never lasts longer than two seconds
// - nonzero kick level gives a pulse before initial torque; zero disables it
// - kick holds for the set duration, 0.1 to 2 s, default 0.8 s
// - dwell start (kick equal to initial level) only in voltage ramp mode
// - decel mode 0: stop command removes output at once
// - decel mode 1: ramp, but an overload trip removes power
// - decel mode 2: ramp continues through an overload trip
// - stop with decel first drops output to begin level, default 60 %
// - starter turns off when ramp reaches shut-off level, default 30 %
// - ramp from begin to shut-off takes at most the set ramp time
// - after power loss, restart is blocked until restart delay elapses
// - imbalance, over and under current scale on full load current; ground on CT
// - every protection trip is off by default, active once level nonzero
// - trip when two phases differ by more than imbalance level for its delay
// - imbalance delay 1 to 20 s, default 2 s
// - trip when any phase exceeds over-current level for its delay
// - over-current delay 1 to 20 s, default 1 s
// - trip when any phase falls below under-current level for its delay
// - under-current delay 1 to 60 s, default 2 s
// - trip when ground current exceeds its percentage of the CT value
// - ground current is the residual sum of the three phase currents
// - ground trip fires only after its delay, 1 to 60 s, default 2 s
//
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
module sskdp_soft_starter #(
  parameter int TICK_CYCLES = sskdp_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // avalon-mm slave
  input  wire logic [5:0]         avsAddress,
  input  wire logic               avsRead,
  input  wire logic               avsWrite,
  input  wire logic [31:0]        avsWriteData,
  input  wire logic [3:0]         avsByteEnable,
  output logic      [31:0]        avsReadData,
  output logic                    avsWaitRequest,
  // power stage measurements
  input  wire logic signed [15:0] phaseCurrentA,
  input  wire logic signed [15:0] phaseCurrentB,
  input  wire logic signed [15:0] phaseCurrentC,
  input  wire logic               linePowerGood,
  input  wire logic               overloadTrip,
  // power stage control
  output logic      [7:0]         voltageRef,
  output logic                    accelRampGo,
  output logic                    tripActive
);
  import sskdp_pkg::*;

  localparam logic [31:0] RST_TABLE [0:REG_COUNT-1] = '{RST_CTRL, RST_KICK, RST_DECEL,
    RST_RESTART, RST_IMBAL, RST_OVERCUR, RST_UNDERCUR, RST_GNDFAULT, RST_MOTOR,
    RST_RAMPINIT, 32'h0000_0000};

  function automatic logic [15:0] absVal(input logic signed [17:0] v);
    logic [17:0] m;
    m = v[17] ? 18'(-v) : 18'(v);
    absVal = (m > 18'h0FFFF) ? 16'hFFFF : m[15:0];
  endfunction

  // scaled compare: current * 100 against percent * base
  function automatic logic [31:0] pctOf(input logic [8:0] pct, input logic [15:0] base);
    pctOf = 32'(pct) * 32'(base);
  endfunction

  function automatic logic [31:0] amps100(input logic [15:0] amps);
    amps100 = 32'(amps) * 32'(PCT_SCALE);
  endfunction

  // avalon slave: one wait cycle, answer on the second edge
  logic              ackReg;
  logic [31:0]       rdDataReg;
  logic [31:0]       cfgReg [0:REG_COUNT-1];
  logic [31:0]       statusWord;
  logic [31:0]       byteMask;
  wire  [3:0]        regIdx    = avsAddress[5:2];
  wire               mapped    = (regIdx < 4'(REG_COUNT));
  wire               wrTake    = avsWrite & ackReg;
  wire               clearPulse = wrTake & (regIdx == IDX_CTRL) & avsByteEnable[0]
                                 & avsWriteData[CTRL_CLEAR_BIT];

  assign avsWaitRequest = (avsRead | avsWrite) & ~ackReg;
  assign avsReadData    = rdDataReg;
  assign byteMask       = {{8{avsByteEnable[3]}}, {8{avsByteEnable[2]}},
                           {8{avsByteEnable[1]}}, {8{avsByteEnable[0]}}};

  always_ff @(posedge clk) begin
    if (rst) begin
      ackReg    <= 1'b0;
      rdDataReg <= 32'h0000_0000;
    end else begin
      ackReg <= (avsRead | avsWrite) & ~ackReg;
      if (avsRead & ~ackReg) begin
        rdDataReg <= !mapped ? 32'h0000_0000 :
                     (regIdx == IDX_STATUS) ? statusWord : cfgReg[regIdx];
      end
    end
  end

  // status word is read-only; the clear bit of control is never stored
  genvar gi;
  generate
    for (gi = 0; gi < REG_COUNT; gi++) begin : g_cfg
      always_ff @(posedge clk) begin
        if (rst) begin
          cfgReg[gi] <= RST_TABLE[gi];
        end else if (wrTake && regIdx == 4'(gi) && gi != IDX_STATUS) begin
          // only the control word drops its clear bit; other words keep bit 1 as data
          cfgReg[gi] <= ((cfgReg[gi] & ~byteMask) | (avsWriteData & byteMask))
                        & ~((gi == IDX_CTRL) ? (32'h1 << CTRL_CLEAR_BIT) : 32'h0);
        end
      end
    end
  endgenerate

  // configuration fields
  wire         runCmd     = cfgReg[IDX_CTRL][CTRL_RUN_BIT];
  wire  [7:0]  kickLevel  = cfgReg[IDX_KICK][7:0];
  wire  [7:0]  kickDur    = cfgReg[IDX_KICK][KICK_DUR_LSB +: 8];
  wire  [1:0]  decelMode  = cfgReg[IDX_DECEL][DEC_MODE_LSB +: 2];
  wire  [7:0]  decelBegin = cfgReg[IDX_DECEL][DEC_BEGIN_LSB +: 8];
  wire  [7:0]  decelShut  = cfgReg[IDX_DECEL][DEC_SHUT_LSB +: 8];
  wire  [7:0]  decelTime  = cfgReg[IDX_DECEL][DEC_TIME_LSB +: 8];
  wire  [9:0]  restartSec = cfgReg[IDX_RESTART][9:0];
  wire  [15:0] fullLoad   = cfgReg[IDX_MOTOR][15:0];
  wire  [15:0] ctValue    = cfgReg[IDX_MOTOR][CT_LSB +: 16];
  wire  [7:0]  rampInitV  = cfgReg[IDX_RAMPINIT][7:0];
  wire         voltMode   = cfgReg[IDX_RAMPINIT][RAMP_VOLT_BIT];

  // 0.1 s tick shared by every timer
  logic [23:0] prescReg;
  wire         tick = (prescReg == 24'(TICK_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (rst || tick) begin
      prescReg <= 24'h00_0000;
    end else begin
      prescReg <= prescReg + 24'h00_0001;
    end
  end

  // current measurements
  wire  [15:0] magA     = absVal(18'(phaseCurrentA));
  wire  [15:0] magB     = absVal(18'(phaseCurrentB));
  wire  [15:0] magC     = absVal(18'(phaseCurrentC));
  wire  [15:0] magMax   = (magA > magB) ? ((magA > magC) ? magA : magC)
                                        : ((magB > magC) ? magB : magC);
  wire  [15:0] magMin   = (magA < magB) ? ((magA < magC) ? magA : magC)
                                        : ((magB < magC) ? magB : magC);
  wire  [15:0] gndCur   = absVal(18'(phaseCurrentA) + 18'(phaseCurrentB)
                                 + 18'(phaseCurrentC));

  // protection conditions, each only while the motor is powered
  logic [NUM_PROT-1:0] protCond;
  logic [8:0]          protLevel [0:NUM_PROT-1];
  logic [7:0]          protDelay [0:NUM_PROT-1];
  logic [NUM_PROT-1:0] protExpire;
  logic [11:0]         protCntReg [0:NUM_PROT-1];
  logic [4:0]          tripReg;
  sskdp_state_e        stateReg;
  sskdp_state_e        stateNext;
  wire                 motorOn = (stateReg == ST_KICK) || (stateReg == ST_ACCEL)
                                 || (stateReg == ST_DECEL);

  generate
    for (gi = 0; gi < NUM_PROT; gi++) begin : g_fld
      assign protLevel[gi] = cfgReg[IDX_IMBAL + 4'(gi)][LVL_LSB +: 9];
      assign protDelay[gi] = cfgReg[IDX_IMBAL + 4'(gi)][DLY_LSB +: 8];
    end
  endgenerate

  assign protCond[TRIP_IMBAL]    = amps100(magMax - magMin)
                                   > pctOf(protLevel[TRIP_IMBAL], fullLoad);
  assign protCond[TRIP_OVERCUR]  = amps100(magMax)
                                   > pctOf(protLevel[TRIP_OVERCUR], fullLoad);
  assign protCond[TRIP_UNDERCUR] = amps100(magMin)
                                   < pctOf(protLevel[TRIP_UNDERCUR], fullLoad);
  assign protCond[TRIP_GNDFAULT] = amps100(gndCur)
                                   > pctOf(protLevel[TRIP_GNDFAULT], ctValue);

  // delay timers count ticks of 0.1 s; a clear fault starts them over
  generate
    for (gi = 0; gi < NUM_PROT; gi++) begin : g_prot
      wire        armed  = motorOn && protLevel[gi] != 9'h000;
      wire [11:0] target = 12'(protDelay[gi]) * 12'(TENTHS_PER_SEC);
      assign protExpire[gi] = armed && protCond[gi] && protCntReg[gi] >= target;
      always_ff @(posedge clk) begin
        if (rst || !(armed && protCond[gi])) begin
          protCntReg[gi] <= 12'h000;
        end else if (tick && protCntReg[gi] < target) begin
          protCntReg[gi] <= protCntReg[gi] + 12'h001;
        end
      end
    end
  endgenerate

  // overload stops a decel ramp in every mode except mode 2
  wire olStops  = overloadTrip && motorOn
                  && !(stateReg == ST_DECEL && decelMode == DECEL_OL_RIDES);
  wire anyTrip  = (|protExpire) || olStops;

  // trip flags are sticky; a new trip beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      tripReg <= 5'h00;
    end else begin
      tripReg <= (clearPulse ? 5'h00 : tripReg) | {olStops, protExpire};
    end
  end

  // restart delay after the line comes back
  logic        pgPrevReg;
  logic [13:0] restartCntReg;
  wire         restartBlocked = (restartCntReg != 14'h0000);

  always_ff @(posedge clk) begin
    if (rst) begin
      pgPrevReg     <= 1'b1;
      restartCntReg <= 14'h0000;
    end else begin
      pgPrevReg <= linePowerGood;
      if (linePowerGood && !pgPrevReg) begin
        restartCntReg <= 14'(restartSec) * 14'(TENTHS_PER_SEC);
      end else if (tick && restartBlocked) begin
        restartCntReg <= restartCntReg - 14'h0001;
      end
    end
  end

  // kick timing, never past two seconds
  logic [7:0] kickCntReg;
  wire  [7:0] kickDurNz  = (kickDur == 8'h00) ? 8'h01 : kickDur;
  wire  [7:0] kickTarget = (kickDurNz > KICK_MAX_TENTHS) ? KICK_MAX_TENTHS : kickDurNz;
  wire        kickDone   = tick && (kickCntReg + 8'h01 >= kickTarget);
  // dwell needs the kick to equal initial torque, which current mode cannot honour
  wire        kickUse    = (kickLevel != 8'h00)
                           && !(kickLevel == rampInitV && !voltMode);

  // decel ramp: bresenham steps of 1 % spread over the ramp time
  logic [7:0]  decelLvlReg;
  logic [15:0] decelAccReg;
  wire  [7:0]  decelSpan  = (decelBegin > decelShut) ? (decelBegin - decelShut) : 8'h00;
  wire  [15:0] decelTen   = 16'(decelTime) * 16'(TENTHS_PER_SEC);
  wire         decelStep  = !tick && decelAccReg >= decelTen && decelLvlReg > decelShut;
  wire         decelEnd   = decelLvlReg <= decelShut;
  wire         stopCmd    = !runCmd || !linePowerGood;
  wire         startOk    = runCmd && linePowerGood && !restartBlocked && tripReg == 5'h00;

  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      ST_IDLE: begin
        if (startOk) begin
          stateNext = kickUse ? ST_KICK : ST_ACCEL;
        end
      end
      ST_KICK: begin
        if (anyTrip) begin
          stateNext = ST_TRIP;
        end else if (stopCmd) begin
          stateNext = ST_IDLE;
        end else if (kickDone) begin
          stateNext = ST_ACCEL;
        end
      end
      ST_ACCEL: begin
        if (anyTrip) begin
          stateNext = ST_TRIP;
        end else if (stopCmd) begin
          stateNext = (decelMode == DECEL_OFF || !linePowerGood)
                      ? ST_IDLE : ST_DECEL;
        end
      end
      ST_DECEL: begin
        if (anyTrip) begin
          stateNext = ST_TRIP;
        end else if (decelEnd || !linePowerGood) begin
          stateNext = ST_IDLE;
        end else if (runCmd) begin
          stateNext = ST_ACCEL;
        end
      end
      ST_TRIP: begin
        if (tripReg == 5'h00) begin
          stateNext = ST_IDLE;
        end
      end
      default: begin
        stateNext = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stateReg <= ST_IDLE;
    end else begin
      stateReg <= stateNext;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || stateReg != ST_KICK) begin
      kickCntReg <= 8'h00;
    end else if (tick) begin
      kickCntReg <= kickCntReg + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      decelLvlReg <= 8'h00;
      decelAccReg <= 16'h0000;
    end else if (stateReg != ST_DECEL) begin
      decelLvlReg <= decelBegin;
      decelAccReg <= 16'(decelSpan); // preload: a late first tick cannot stretch the ramp
    end else if (tick) begin
      decelAccReg <= decelAccReg + 16'(decelSpan);
    end else if (decelStep) begin
      decelAccReg <= decelAccReg - decelTen;
      decelLvlReg <= decelLvlReg - 8'h01;
    end
  end

  // outputs come from flops; a trip forces the reference to zero
  logic [7:0] voltSel;
  logic       goReg;
  logic       tripOutReg;
  logic [7:0] voltRefReg;

  assign voltSel = (stateReg == ST_KICK)  ? kickLevel :
                   (stateReg == ST_ACCEL) ? rampInitV :
                   (stateReg == ST_DECEL) ? decelLvlReg : 8'h00;

  always_ff @(posedge clk) begin
    if (rst) begin
      voltRefReg <= 8'h00;
      goReg      <= 1'b0;
      tripOutReg <= 1'b0;
    end else begin
      voltRefReg <= voltSel;
      goReg      <= (stateReg == ST_ACCEL);
      tripOutReg <= (stateReg == ST_TRIP);
    end
  end

  assign voltageRef  = voltRefReg;
  assign accelRampGo = goReg;
  assign tripActive  = tripOutReg;
  assign statusWord  = {8'h00, decelLvlReg, restartBlocked, 2'h0, tripReg,
                        voltRefReg[7:3] == 5'h00 ? 1'b0 : 1'b1, 4'h0, 3'(stateReg)};

  chk_kick_limit: assert property (@(posedge clk) disable iff (rst)
    stateReg == ST_KICK |-> kickCntReg < KICK_MAX_TENTHS)
    else $error("kick pulse ran past two seconds");
  chk_kick_level: assert property (@(posedge clk) disable iff (rst)
    stateReg == ST_KICK |=> voltageRef == $past(kickLevel))
    else $error("kick output not at kick level");
  chk_kick_skip: assert property (@(posedge clk) disable iff (rst)
    (stateReg == ST_IDLE && startOk && kickLevel == 8'h00) |=> stateReg == ST_ACCEL)
    else $error("zero kick level did not skip the kick");
  chk_dwell_mode: assert property (@(posedge clk) disable iff (rst)
    $rose(stateReg == ST_KICK) |-> !($past(kickLevel) == $past(rampInitV) && !$past(voltMode)))
    else $error("dwell kick taken in current ramp mode");
  chk_stop_nodecel: assert property (@(posedge clk) disable iff (rst)
    (stateReg == ST_ACCEL && !runCmd && decelMode == DECEL_OFF && !anyTrip)
    |=> stateReg == ST_IDLE ##1 voltageRef == 8'h00)
    else $error("stop without decel kept output");
  chk_decel_begin: assert property (@(posedge clk) disable iff (rst)
    (stateReg == ST_ACCEL && !runCmd && linePowerGood && decelMode != DECEL_OFF && !anyTrip)
    |=> stateReg == ST_DECEL ##1 voltageRef == $past(decelBegin, 2))
    else $error("decel did not start at begin level");
  chk_decel_ol1: assert property (@(posedge clk) disable iff (rst)
    (stateReg == ST_DECEL && overloadTrip && decelMode == DECEL_OL_STOPS) |=> stateReg == ST_TRIP)
    else $error("overload did not stop decel in mode one");
  chk_decel_ol2: assert property (@(posedge clk) disable iff (rst)
    (stateReg == ST_DECEL && overloadTrip && decelMode == DECEL_OL_RIDES && !(|protExpire))
    |=> stateReg != ST_TRIP)
    else $error("overload ended decel in mode two");
  chk_shutoff_end: assert property (@(posedge clk) disable iff (rst)
    (stateReg == ST_DECEL && decelEnd && !anyTrip) |=> stateReg == ST_IDLE)
    else $error("decel ran below shut-off level");
  chk_restart_hold: assert property (@(posedge clk) disable iff (rst)
    (stateReg == ST_IDLE && restartBlocked) |=> stateReg == ST_IDLE)
    else $error("start taken during restart delay");
  chk_timer_clear: assert property (@(posedge clk) disable iff (rst)
    !protCond[TRIP_OVERCUR] |=> protCntReg[TRIP_OVERCUR] == 12'h000)
    else $error("over-current timer kept count after fault cleared");
  chk_trip_off: assert property (@(posedge clk) disable iff (rst)
    (|protExpire) |=> stateReg == ST_TRIP ##2 (voltageRef == 8'h00 && tripActive))
    else $error("expired timer did not remove output");
endmodule // sskdp_soft_starter

// [sim/sskdp_power_stage.sv]
// power stage and current sensor model for the soft starter bench
module sskdp_power_stage (
  // clock and motor drive
  input  wire logic               clk,
  input  wire logic [7:0]         voltageRef,
  // phase current amplitudes set by the bench
  input  wire logic [15:0]        magA,
  input  wire logic [15:0]        magB,
  input  wire logic [15:0]        magC,
  // sensed phase currents
  output logic signed [15:0]      phaseCurrentA,
  output logic signed [15:0]      phaseCurrentB,
  output logic signed [15:0]      phaseCurrentC
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip = 1'b0;
  logic on;
  // no voltage, no current: an idle motor must not look loaded
  assign on = (voltageRef != 8'h00);
  // sign flips each cycle, b opposes a so only the c residual reaches ground
  always_ff @(posedge clk) begin
    flip <= ~flip;
    phaseCurrentA <= !on ? 16'sh0000 : flip ? -$signed(magA) : $signed(magA);
    phaseCurrentB <= !on ? 16'sh0000 : flip ? $signed(magB) : -$signed(magB);
    phaseCurrentC <= !on ? 16'sh0000 : flip ? -$signed(magC) : $signed(magC);
  end
endmodule // sskdp_power_stage

// [sim/tb_sskdp_soft_starter.sv]
// self-checking bench for the soft starter sequencer
module tb_sskdp_soft_starter;
  timeunit 1ns;
  timeprecision 1ps;
  import sskdp_pkg::*;
  localparam int TK = 10;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [5:0]  avsAddress = 6'h00;
  logic        avsRead = 1'b0;
  logic        avsWrite = 1'b0;
  logic [31:0] avsWriteData = 32'h0;
  logic [31:0] avsReadData, rd;
  logic        avsWaitRequest, accelRampGo, tripActive;
  logic        linePowerGood = 1'b1;
  logic        overloadTrip = 1'b0;
  logic signed [15:0] phaseCurrentA, phaseCurrentB, phaseCurrentC;
  logic [15:0] magA = 16'h0064, magB = 16'h0064, magC = 16'h0064;
  logic [7:0]  voltageRef;
  int          num_errors = 0, total_checks = 0, cyc = 0, n, k;
  logic [31:0] rstv [1:9] = '{RST_KICK, RST_DECEL, RST_RESTART, RST_IMBAL, RST_OVERCUR,
                              RST_UNDERCUR, RST_GNDFAULT, RST_MOTOR, RST_RAMPINIT};
  logic [3:0]  pi [4] = '{IDX_IMBAL, IDX_OVERCUR, IDX_UNDERCUR, IDX_GNDFAULT};
  logic [8:0]  pl [4] = '{9'h00A, 9'h096, 9'h032, 9'h00A};
  logic [15:0] pm [4] = '{16'h0064, 16'h00C8, 16'h0064, 16'h0064};
  logic [15:0] pc [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0014};

  always #4 clk = ~clk;

  sskdp_soft_starter #(.TICK_CYCLES(TK)) sskdp_soft_starter_inst (
    .clk(clk), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsByteEnable(4'hF), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .phaseCurrentA(phaseCurrentA),
    .phaseCurrentB(phaseCurrentB), .phaseCurrentC(phaseCurrentC),
    .linePowerGood(linePowerGood), .overloadTrip(overloadTrip), .voltageRef(voltageRef),
    .accelRampGo(accelRampGo), .tripActive(tripActive));
  sskdp_power_stage sskdp_power_stage_inst (
    .clk(clk), .voltageRef(voltageRef), .magA(magA), .magB(magB), .magC(magC),
    .phaseCurrentA(phaseCurrentA), .phaseCurrentB(phaseCurrentB),
    .phaseCurrentC(phaseCurrentC));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkr(input string nm, input int lo, input int hi, input int g);
    total_checks++;
    if (g < lo || g > hi) begin
      num_errors++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  // one access: request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] d);
    @(posedge clk);
    avsAddress <= {idx, 2'b00};
    avsWrite <= wr;
    avsRead <= ~wr;
    avsWriteData <= d;
    do @(posedge clk); while (avsWaitRequest !== 1'b0);
    rd = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask
  task automatic waitRef(input logic [7:0] v);
    n = 0;
    while (voltageRef !== v && n < 3000) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic stop_test();
    if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard, well above the roughly one thousand cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      stop_test();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 1; i < 10; i++) begin
      bus(1'b0, i[3:0], 32'h0);
      chk("reset value", rstv[i], rd);
    end
    bus(1'b0, 4'hB, 32'h0);
    chk("unmapped read", 32'h0, rd);
    // kick at 90 %, short and over-long duration
    for (int d = 3; d < 40; d += 27) begin
      bus(1'b1, IDX_KICK, {16'h0, d[7:0], 8'h5A});
      bus(1'b1, IDX_CTRL, 32'h1);
      waitRef(8'h5A);
      k = 0;
      while (voltageRef === 8'h5A && k < 400) begin
        @(posedge clk);
        k++;
      end
      chkr("kick length", ((d > 20 ? 20 : d) - 1) * TK, (d > 20 ? 20 : d) * TK + 2, k);
      chk("accel ref", 32'h3C, 32'(voltageRef));
      chk("accel go", 32'h1, 32'(accelRampGo));
      bus(1'b1, IDX_CTRL, 32'h0);
      repeat (4) @(posedge clk);
      chk("stop ref", 32'h0, 32'(voltageRef));
      chk("stop go", 32'h0, 32'(accelRampGo));
    end
    // dwell: kick equal to initial level, kept only in voltage ramp mode
    for (int v = 0; v < 2; v++) begin
      bus(1'b1, IDX_RAMPINIT, {23'h0, v[0], 8'h3C});
      bus(1'b1, IDX_KICK, 32'h0000_083C);
      bus(1'b1, IDX_CTRL, 32'h1);
      bus(1'b0, IDX_STATUS, 32'h0);
      chk("dwell state", v == 1 ? 32'h1 : 32'h2, rd & 32'h7);
      bus(1'b1, IDX_CTRL, 32'h0);
      waitRef(8'h00);
    end
    bus(1'b1, IDX_KICK, RST_KICK);
    // decel from 50 to 30 in 1 s, overload mid-ramp
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, IDX_DECEL, {8'h01, 8'h1E, 8'h32, 6'h0, m[1:0]});
      bus(1'b1, IDX_CTRL, 32'h1);
      waitRef(8'h3C);
      bus(1'b1, IDX_CTRL, 32'h0);
      repeat (3) @(posedge clk);
      chk("decel begin", m == 0 ? 32'h0 : 32'h32, 32'(voltageRef));
      if (m > 0) begin
        overloadTrip <= 1'b1;
        repeat (4) @(posedge clk);
        chk("overload trip", {31'h0, m == 1}, {31'h0, tripActive});
        waitRef(8'h00);
        chkr("decel span", m == 1 ? 0 : 20, m == 1 ? 3 : 105, n);
        overloadTrip <= 1'b0;
        bus(1'b1, IDX_CTRL, 32'h2);
      end
    end
    bus(1'b1, IDX_DECEL, RST_DECEL);
    // each protection at 1 s delay; index order matches trip flag order
    for (int p = 0; p < 4; p++) begin
      magA <= pm[p];
      magB <= pm[p];
      magC <= pc[p];
      bus(1'b1, pi[p], {16'h0001, 7'h0, pl[p]});
      bus(1'b1, IDX_CTRL, 32'h1);
      k = 0;
      while (tripActive !== 1'b1 && k < 400) begin
        @(posedge clk);
        k++;
      end
      chkr("trip delay", 88, 115, k);
      chk("trip ref", 32'h0, 32'(voltageRef));
      bus(1'b0, IDX_STATUS, 32'h0);
      chk("trip flag", 32'h100 << p, rd & 32'h1F00);
      bus(1'b1, pi[p], 32'h0001_0000);
      bus(1'b1, IDX_CTRL, 32'h2);
    end
    magC <= 16'h0064;
    // power loss then start within the restart delay
    bus(1'b1, IDX_RESTART, 32'h1);
    linePowerGood <= 1'b0;
    repeat (4) @(posedge clk);
    linePowerGood <= 1'b1;
    bus(1'b1, IDX_CTRL, 32'h1);
    waitRef(8'h3C);
    chkr("restart delay", 85, 106, n + 3);
    stop_test();
  end
endmodule // tb_sskdp_soft_starter
